// ==== hw/nvm_cmd_map.vh ====
`ifndef NVM_CMD_MAP_VH
`define NVM_CMD_MAP_VH

// ====
// register offsets
`define OFS_PROT 4'h1
`define OFS_IRQ_EN 4'h2
`define OFS_IRQ_CLR 4'h3
`define OFS_IRQ_STAT 4'h4
`define OFS_STATUS 4'h5
`define OFS_CMD 4'h6
`define OFS_RSVD 4'h7
`define OFS_ADDR_HI 4'h8
`define OFS_ADDR_LO 4'h9
`define OFS_DATA_HI 4'hA
`define OFS_DATA_LO 4'hB

// ====
// protection register fields
`define PROT_OPEN_BIT 7
`define PROT_HDIS_BIT 5
`define PROT_HS_MSB 4
`define PROT_HS_LSB 3
`define PROT_LDIS_BIT 2
`define PROT_LS_MSB 1
`define PROT_LS_LSB 0
`define PROT_RST 8'hFF

// ====
// status register bits
`define ST_BUF_EMPTY_BIT 7
`define ST_DONE_BIT 6
`define ST_PVIOL_BIT 5
`define ST_ACCESS_ERROR_FLAG_BIT 4
`define ST_BLANK_BIT 2

// ====
// interrupt bits
`define IRQ_W 4
`define IRQ_DONE_BIT 0
`define IRQ_BUF_BIT 1
`define IRQ_ACC_BIT 2
`define IRQ_PV_BIT 3

// ====
// command codes
`define CMD_VERIFY 8'h05
`define CMD_PROG 8'h20
`define CMD_SECT_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41
`define CMD_IMPL_MASK 8'h65

// ====
// protection windows
`define HI_BASE_2K 16'hF800
`define HI_BASE_4K 16'hF000
`define HI_BASE_8K 16'hE000
`define HI_BASE_16K 16'hC000
`define LO_BASE 16'h4000
`define LO_END_512 16'h41FF
`define LO_END_1K 16'h43FF
`define LO_END_2K 16'h47FF
`define LO_END_4K 16'h4FFF

// ====
// array contents and timing
`define ERASED_WORD 16'hFFFF
`define PROG_TIME_NS 20000
`define CLK_MHZ 100

`endif

// ==== hw/nvm_word_mem.v ====
`timescale 1ns/1ps
`default_nettype none
`include "nvm_cmd_map.vh"

// single-port word array, registered read data, erased at power-up
module nvm_word_mem #(
    parameter AW = 15
) (
    input wire ref_clk,
    input wire wr_en,
    input wire [AW-1:0] addr,
    input wire [15:0] wdata,
    output reg [15:0] rdata
);

    reg [15:0] cells [0:(1<<AW)-1];
    integer i;

    // ====
    // power-up contents: every bit erased
    initial begin
        for (i = 0; i < (1 << AW); i = i + 1) begin
            cells[i] = `ERASED_WORD;
        end
    end

    // read first: a write cycle returns the old word, read data always from a register
    always @(posedge ref_clk) begin
        if (wr_en) begin
            cells[addr] <= wdata;
        end
        rdata <= cells[addr];
    end

endmodule
`default_nettype wire

// ==== hw/prot_window_check.v ====
`timescale 1ns/1ps
`default_nettype none
`include "nvm_cmd_map.vh"

// decides whether one byte address is protected under a setting
module prot_window_check (
    input wire [7:0] prot_cfg,
    input wire [15:0] addr,
    output reg prot
);

    reg [15:0] hi_base;
    reg [15:0] lo_end;
    reg in_hi;
    reg in_lo;
    reg in_win;

    // ====
    // window bounds from the size fields
    always @* begin
        case (prot_cfg[`PROT_HS_MSB:`PROT_HS_LSB]) // see RULE_03
            2'b00: hi_base = `HI_BASE_2K;
            2'b01: hi_base = `HI_BASE_4K;
            2'b10: hi_base = `HI_BASE_8K;
            default: hi_base = `HI_BASE_16K;
        endcase
        case (prot_cfg[`PROT_LS_MSB:`PROT_LS_LSB]) // see RULE_04
            2'b00: lo_end = `LO_END_512;
            2'b01: lo_end = `LO_END_1K;
            2'b10: lo_end = `LO_END_2K;
            default: lo_end = `LO_END_4K;
        endcase
        in_hi = (addr >= hi_base) && !prot_cfg[`PROT_HDIS_BIT];
        in_lo = (addr >= `LO_BASE) && (addr <= lo_end) && !prot_cfg[`PROT_LDIS_BIT];
        in_win = in_hi || in_lo;
        // open mode guards the windows, closed mode guards the rest
        if (prot_cfg[`PROT_OPEN_BIT]) begin
            prot = in_win; // see RULE_01
        end else begin
            prot = !in_win; // see RULE_02
        end
    end

endmodule
`default_nettype wire

// ==== hw/flash_protect_cmd_check.v ====
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_cmd_map.vh"

// Function
// RULE_01: open mode protects windows not disabled
// RULE_02: closed mode protects all except enabled windows
// RULE_03: high window size field selects 2K-16K
// RULE_04: low window size field selects 512-4K
// RULE_05: protection loaded after reset, software-writable
// RULE_06: only four command codes, bits 6,5,2,0
// RULE_07: invalid command launch sets access error
// RULE_08: reserved register reads zero, ignores writes
// RULE_09: aligned reads one cycle, misaligned two
// RULE_10: no array reads while operation runs
// RULE_11: erased bit reads one, programmed zero
// RULE_12: software programs only erased words
// RULE_13: software launches with three-step write sequence
// RULE_14: two-stage command pipeline with interrupts
// RULE_15: rejected commands never touch the array
module flash_protect_cmd_check #(
    parameter AW = 15,
    parameter SECT_LOG2 = 9,
    parameter PROG_TIME_NS = `PROG_TIME_NS,
    parameter [15:0] PROT_CFG_ADDR = 16'hFFFE
) (
    input wire ref_clk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire arr_rd,
    input wire [15:0] arr_addr,
    input wire arr_byte,
    output reg [15:0] arr_rdata,
    output reg arr_valid,
    output reg arr_refused,
    output reg busy,
    output reg irq
);

    // ====
    // constants
    localparam integer PROG_CYC_I = (PROG_TIME_NS * `CLK_MHZ + 999) / 1000;
    localparam [15:0] PROG_CYC = PROG_CYC_I[15:0];
    localparam [31:0] SECT_WM32 = (32'h1 << SECT_LOG2) - 32'h1;
    localparam [AW-1:0] SECT_WMASK = SECT_WM32[AW-1:0];
    localparam [15:0] SECT_BMASK = {SECT_WM32[14:0], 1'b1};
    localparam [AW-1:0] LAST_WORD = {AW{1'b1}};

    localparam [2:0] S_LOAD = 3'h0;
    localparam [2:0] S_LOADW = 3'h1;
    localparam [2:0] S_IDLE = 3'h2;
    localparam [2:0] S_PROG = 3'h3;
    localparam [2:0] S_ERASE = 3'h4;
    localparam [2:0] S_VRD = 3'h5;
    localparam [2:0] S_VCHK = 3'h6;
    localparam [2:0] S_DONE = 3'h7;

    localparam [1:0] RP_IDLE = 2'h0;
    localparam [1:0] RP_ONE = 2'h1;
    localparam [1:0] RP_MIS1 = 2'h2;
    localparam [1:0] RP_MIS2 = 2'h3;

    // ====
    // state
    reg [2:0] state_ff;
    reg [7:0] prot_ff;
    reg [`IRQ_W-1:0] irq_en_ff;
    reg [`IRQ_W-1:0] irq_stat_ff;
    reg access_error_flag_ff;
    reg pviol_ff;
    reg blank_ff;
    reg [7:0] cmd_ff;
    reg [7:0] addr_hi_ff;
    reg [7:0] addr_lo_ff;
    reg [7:0] data_hi_ff;
    reg [7:0] data_lo_ff;
    reg buf_v_ff;
    reg [7:0] buf_cmd_ff;
    reg [15:0] buf_addr_ff;
    reg [15:0] buf_data_ff;
    reg [15:0] act_data_ff;
    reg [AW-1:0] ptr_ff;
    reg [AW-1:0] end_ff;
    reg [15:0] cnt_ff;
    reg [1:0] rd_ph_ff;
    reg [15:0] rd_addr_ff;
    reg rd_byte_ff;
    reg [7:0] rd_lo_ff;

    wire [15:0] mem_q;
    wire [15:0] cmd_addr;
    wire [15:0] sect_end;
    wire prot_at;
    wire prot_end;
    reg mem_we;
    reg [AW-1:0] mem_addr;
    reg [15:0] mem_wd;
    reg [7:0] status_byte;
    reg [7:0] rd_mux;

    // ====
    // launch checks
    assign cmd_addr = {addr_hi_ff, addr_lo_ff};
    assign sect_end = cmd_addr | SECT_BMASK;

    wire wr_status = reg_wr && (reg_addr == `OFS_STATUS);
    wire launch = wr_status && reg_wdata[`ST_BUF_EMPTY_BIT];
    wire is_prog = (cmd_ff == `CMD_PROG);
    wire is_sect = (cmd_ff == `CMD_SECT_ERASE);
    wire is_mass = (cmd_ff == `CMD_MASS_ERASE);
    wire cmd_ok = is_prog || is_sect || is_mass || (cmd_ff == `CMD_VERIFY); // see RULE_06
    wire prot_any = !prot_ff[`PROT_OPEN_BIT] || !prot_ff[`PROT_HDIS_BIT] || !prot_ff[`PROT_LDIS_BIT];
    wire blocked = (is_prog && prot_at) || (is_sect && (prot_at || prot_end)) || (is_mass && prot_any);
    wire ev_acc = launch && (!cmd_ok || buf_v_ff); // see RULE_07
    wire ev_pv = launch && cmd_ok && !buf_v_ff && blocked;
    wire push = launch && cmd_ok && !buf_v_ff && !blocked; // see RULE_15
    wire pop = (state_ff == S_IDLE) && buf_v_ff && (rd_ph_ff == RP_IDLE);
    wire ev_done = (state_ff == S_DONE);
    wire busy_now = buf_v_ff || (state_ff != S_IDLE);
    wire [`IRQ_W-1:0] ev_vec = {ev_pv, ev_acc, pop, ev_done};
    wire irq_clr_wr = reg_wr && (reg_addr == `OFS_IRQ_CLR);
    wire [`IRQ_W-1:0] clr_vec = irq_clr_wr ? reg_wdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
    wire [`IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~clr_vec) | ev_vec;

    // ====
    // protection checks on target address and sector end
    prot_window_check u_prot_at (
        .prot_cfg(prot_ff),
        .addr(cmd_addr),
        .prot(prot_at)
    );

    prot_window_check u_prot_end (
        .prot_cfg(prot_ff),
        .addr(sect_end),
        .prot(prot_end)
    );

    // ====
    // array port: sequencer owns it when active, reads otherwise
    always @* begin
        mem_we = 1'b0;
        mem_wd = act_data_ff;
        mem_addr = arr_addr[AW:1];
        case (state_ff)
            S_LOAD: begin
                mem_addr = PROT_CFG_ADDR[AW:1];
            end
            S_PROG: begin
                mem_we = (cnt_ff == 16'h0001);
                mem_addr = ptr_ff;
            end
            S_ERASE: begin
                mem_we = 1'b1;
                mem_addr = ptr_ff;
                mem_wd = `ERASED_WORD; // see RULE_11
            end
            S_VRD: begin
                mem_addr = ptr_ff;
            end
            default: begin
                if (rd_ph_ff == RP_MIS1) begin
                    mem_addr = rd_addr_ff[AW:1] + {{(AW-1){1'b0}}, 1'b1};
                end
            end
        endcase
    end

    nvm_word_mem #(
        .AW(AW)
    ) u_mem (
        .ref_clk(ref_clk),
        .wr_en(mem_we),
        .addr(mem_addr),
        .wdata(mem_wd),
        .rdata(mem_q)
    );

    // ====
    // register read mux
    always @* begin
        status_byte = 8'h00;
        status_byte[`ST_BUF_EMPTY_BIT] = !buf_v_ff;
        status_byte[`ST_DONE_BIT] = !busy_now;
        status_byte[`ST_PVIOL_BIT] = pviol_ff;
        status_byte[`ST_ACCESS_ERROR_FLAG_BIT] = access_error_flag_ff;
        status_byte[`ST_BLANK_BIT] = blank_ff;
        case (reg_addr)
            `OFS_PROT: rd_mux = prot_ff;
            `OFS_IRQ_EN: rd_mux = {{(8-`IRQ_W){1'b0}}, irq_en_ff};
            `OFS_IRQ_STAT: rd_mux = {{(8-`IRQ_W){1'b0}}, irq_stat_ff};
            `OFS_STATUS: rd_mux = status_byte;
            `OFS_CMD: rd_mux = cmd_ff;
            `OFS_RSVD: rd_mux = 8'h00; // see RULE_08
            `OFS_ADDR_HI: rd_mux = addr_hi_ff;
            `OFS_ADDR_LO: rd_mux = addr_lo_ff;
            `OFS_DATA_HI: rd_mux = data_hi_ff;
            `OFS_DATA_LO: rd_mux = data_lo_ff;
            default: rd_mux = 8'h00;
        endcase
    end

    // ====
    // register file, flags and interrupt output
    always @(posedge ref_clk) begin
        if (rst) begin
            prot_ff <= `PROT_RST;
            irq_en_ff <= {`IRQ_W{1'b0}};
            irq_stat_ff <= {`IRQ_W{1'b0}};
            access_error_flag_ff <= 1'b0;
            pviol_ff <= 1'b0;
            cmd_ff <= 8'h00;
            addr_hi_ff <= 8'h00;
            addr_lo_ff <= 8'h00;
            data_hi_ff <= 8'h00;
            data_lo_ff <= 8'h00;
            reg_rdata <= 8'h00;
            irq <= 1'b0;
            busy <= 1'b1;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            irq_stat_ff <= nxt_irq_stat; // see RULE_14
            irq <= |(irq_stat_ff & irq_en_ff);
            busy <= busy_now;
            // a flag event in the clearing cycle keeps the flag set
            access_error_flag_ff <= ev_acc || (access_error_flag_ff && !(wr_status && reg_wdata[`ST_ACCESS_ERROR_FLAG_BIT]));
            pviol_ff <= ev_pv || (pviol_ff && !(wr_status && reg_wdata[`ST_PVIOL_BIT]));
            if (reg_wr) begin
                case (reg_addr)
                    `OFS_PROT: prot_ff <= reg_wdata; // see RULE_05
                    `OFS_IRQ_EN: irq_en_ff <= reg_wdata[`IRQ_W-1:0];
                    `OFS_CMD: cmd_ff <= reg_wdata & `CMD_IMPL_MASK; // see RULE_06
                    `OFS_ADDR_HI: addr_hi_ff <= reg_wdata;
                    `OFS_ADDR_LO: addr_lo_ff <= reg_wdata;
                    `OFS_DATA_HI: data_hi_ff <= reg_wdata;
                    `OFS_DATA_LO: data_lo_ff <= reg_wdata;
                    default: ;
                endcase
            end
            // the array-loaded setting beats a same-cycle write
            if (state_ff == S_LOADW) begin
                prot_ff <= PROT_CFG_ADDR[0] ? mem_q[7:0] : mem_q[15:8]; // see RULE_05
            end
        end
    end

    // ====
    // command buffer stage and sequencer stage
    always @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= S_LOAD;
            buf_v_ff <= 1'b0;
            buf_cmd_ff <= 8'h00;
            buf_addr_ff <= 16'h0000;
            buf_data_ff <= 16'h0000;
            act_data_ff <= 16'h0000;
            ptr_ff <= {AW{1'b0}};
            end_ff <= {AW{1'b0}};
            cnt_ff <= 16'h0000;
            blank_ff <= 1'b0;
        end else begin
            if (push) begin
                buf_v_ff <= 1'b1; // see RULE_14
                buf_cmd_ff <= cmd_ff;
                buf_addr_ff <= cmd_addr;
                buf_data_ff <= {data_hi_ff, data_lo_ff};
            end else if (pop) begin
                buf_v_ff <= 1'b0;
            end
            case (state_ff)
                S_LOAD: begin
                    state_ff <= S_LOADW;
                end
                S_LOADW: begin
                    state_ff <= S_IDLE;
                end
                S_IDLE: begin
                    if (pop) begin
                        act_data_ff <= buf_data_ff;
                        case (buf_cmd_ff)
                            `CMD_PROG: begin
                                ptr_ff <= buf_addr_ff[AW:1];
                                cnt_ff <= PROG_CYC;
                                state_ff <= S_PROG;
                            end
                            `CMD_SECT_ERASE: begin
                                ptr_ff <= buf_addr_ff[AW:1] & ~SECT_WMASK;
                                end_ff <= buf_addr_ff[AW:1] | SECT_WMASK;
                                state_ff <= S_ERASE;
                            end
                            `CMD_MASS_ERASE: begin
                                ptr_ff <= {AW{1'b0}};
                                end_ff <= LAST_WORD;
                                state_ff <= S_ERASE;
                            end
                            default: begin
                                ptr_ff <= {AW{1'b0}};
                                end_ff <= LAST_WORD;
                                blank_ff <= 1'b1;
                                state_ff <= S_VRD;
                            end
                        endcase
                    end
                end
                S_PROG: begin
                    cnt_ff <= cnt_ff - 16'h0001;
                    if (cnt_ff == 16'h0001) begin
                        state_ff <= S_DONE;
                    end
                end
                S_ERASE: begin
                    ptr_ff <= ptr_ff + {{(AW-1){1'b0}}, 1'b1};
                    if (ptr_ff == end_ff) begin
                        state_ff <= S_DONE;
                    end
                end
                S_VRD: begin
                    state_ff <= S_VCHK;
                end
                S_VCHK: begin
                    if (mem_q != `ERASED_WORD) begin
                        blank_ff <= 1'b0;
                    end
                    if (ptr_ff == end_ff) begin
                        state_ff <= S_DONE;
                    end else begin
                        ptr_ff <= ptr_ff + {{(AW-1){1'b0}}, 1'b1};
                        state_ff <= S_VRD;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // ====
    // array read path
    always @(posedge ref_clk) begin
        if (rst) begin
            rd_ph_ff <= RP_IDLE;
            rd_addr_ff <= 16'h0000;
            rd_byte_ff <= 1'b0;
            rd_lo_ff <= 8'h00;
            arr_rdata <= 16'h0000;
            arr_valid <= 1'b0;
            arr_refused <= 1'b0;
        end else begin
            arr_valid <= 1'b0;
            arr_refused <= 1'b0;
            case (rd_ph_ff)
                RP_IDLE: begin
                    if (arr_rd) begin
                        if (busy_now) begin
                            arr_refused <= 1'b1; // see RULE_10
                        end else begin
                            rd_addr_ff <= arr_addr;
                            rd_byte_ff <= arr_byte;
                            // misaligned word needs a second array fetch
                            rd_ph_ff <= (!arr_byte && arr_addr[0]) ? RP_MIS1 : RP_ONE; // see RULE_09
                        end
                    end
                end
                RP_ONE: begin
                    if (rd_byte_ff) begin
                        arr_rdata <= {8'h00, rd_addr_ff[0] ? mem_q[7:0] : mem_q[15:8]};
                    end else begin
                        arr_rdata <= mem_q;
                    end
                    arr_valid <= 1'b1;
                    rd_ph_ff <= RP_IDLE;
                end
                RP_MIS1: begin
                    rd_lo_ff <= mem_q[7:0];
                    arr_refused <= arr_rd;
                    rd_ph_ff <= RP_MIS2;
                end
                default: begin
                    arr_rdata <= {rd_lo_ff, mem_q[15:8]}; // see RULE_09
                    arr_valid <= 1'b1;
                    rd_ph_ff <= RP_IDLE;
                end
            endcase
            if (rd_ph_ff == RP_ONE || rd_ph_ff == RP_MIS2) begin
                arr_refused <= arr_rd;
            end
        end
    end

endmodule
`default_nettype wire

// ==== verification/flash_protect_cmd_check_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nvm_cmd_map.vh"

// ====
// port checker for the command front end
module flash_protect_cmd_check_sva (
    input wire ref_clk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire arr_rd,
    input wire [15:0] arr_addr,
    input wire arr_byte,
    input wire [15:0] arr_rdata,
    input wire arr_valid,
    input wire arr_refused,
    input wire busy,
    input wire irq
);
    // every check runs on the bus clock and sleeps in reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // reads by alignment, and write, gap, read of one place
    sequence s_aln;
        arr_rd && (arr_byte || !arr_addr[0]);
    endsequence
    sequence s_mis;
        arr_rd && !arr_byte && arr_addr[0];
    endsequence
    sequence s_wr_rd(a);
        reg_wr && reg_addr == a ##1 !reg_wr ##1 reg_rd && reg_addr == a;
    endsequence

    // properties
    property p_aligned;
        s_aln |=> arr_refused or (!arr_valid ##1 arr_valid);
    endproperty
    property p_misaligned;
        s_mis |=> arr_refused or (!arr_valid ##1 !arr_valid ##1 arr_valid);
    endproperty
    property p_hold;
        !arr_valid && !$past(rst) |-> $stable(arr_rdata);
    endproperty
    property p_busy_refuse;
        arr_rd ##1 busy |-> arr_refused;
    endproperty
    property p_rsvd;
        reg_rd && reg_addr == `OFS_RSVD |=> reg_rdata == 8'h00;
    endproperty
    property p_cmd_store;
        s_wr_rd(`OFS_CMD) |=> reg_rdata == ($past(reg_wdata, 3) & `CMD_IMPL_MASK);
    endproperty
    property p_prot_wr;
        s_wr_rd(`OFS_PROT) |=> (reg_rdata & 8'hBF) == ($past(reg_wdata, 3) & 8'hBF);
    endproperty
    property p_irq_mask;
        reg_wr && reg_addr == `OFS_IRQ_EN && reg_wdata[3:0] == 4'h0 |-> ##2 !irq;
    endproperty
    property p_load;
        $fell(rst) |-> busy ##1 busy ##[1:3] !busy;
    endproperty

    a_aligned: assert property (p_aligned)
        else $error("aligned read late");
    a_misaligned: assert property (p_misaligned)
        else $error("misaligned read late");
    a_hold: assert property (p_hold)
        else $error("read data moved without valid");
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("array read served while busy");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved register not zero");
    a_cmd_store: assert property (p_cmd_store)
        else $error("command code bits wrong");
    a_prot_wr: assert property (p_prot_wr)
        else $error("protection setting not writable");
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt high while masked");
    a_load: assert property (p_load)
        else $error("reset load timing wrong");
endmodule

bind flash_protect_cmd_check flash_protect_cmd_check_sva u_sva (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_rd(arr_rd),
    .arr_addr(arr_addr), .arr_byte(arr_byte), .arr_rdata(arr_rdata), .arr_valid(arr_valid),
    .arr_refused(arr_refused), .busy(busy), .irq(irq)
);
`default_nettype wire

// ==== verification/test_flash_protect_cmd_check.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nvm_cmd_map.vh"

// ====
// bench for the command and protection front end
module test_flash_protect_cmd_check;
    logic ref_clk, rst, reg_wr, reg_rd, arr_rd, arr_byte, arr_valid, arr_refused, busy, irq;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd8;
    logic [15:0] arr_addr, arr_rdata, rd16;
    logic [1:0] res;
    int num_errors = 0;
    int total_checks = 0;

    flash_protect_cmd_check #(.AW(7), .SECT_LOG2(4), .PROG_TIME_NS(300)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_rd(arr_rd),
        .arr_addr(arr_addr), .arr_byte(arr_byte), .arr_rdata(arr_rdata), .arr_valid(arr_valid),
        .arr_refused(arr_refused), .busy(busy), .irq(irq)
    );

    // 100 MHz bus clock
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ====
    // shared tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask

    // one array read; r is 1 for data, 2 for refusal
    task automatic arr_read(input logic [15:0] a, input logic b, output logic [15:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        arr_rd <= 1'h1;
        arr_addr <= a;
        arr_byte <= b;
        @(posedge ref_clk);
        arr_rd <= 1'h0;
        r = 2'h0;
        for (int i = 0; i < 6 && r == 2'h0; i++) begin
            #1;
            if (arr_valid === 1'h1) r = 2'h1;
            else if (arr_refused === 1'h1) r = 2'h2;
            else @(posedge ref_clk);
        end
        d = arr_rdata;
        if (r == 2'h0) begin
            num_errors++;
            finish_test();
        end
    endtask

    task automatic wait_idle();
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 3000; i++) begin
            #1;
            if (busy === 1'h0) return;
            @(posedge ref_clk);
        end
        num_errors++;
        finish_test();
    endtask

    task automatic launch(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d);
        reg_write(`OFS_CMD, c);
        reg_write(`OFS_ADDR_HI, a[15:8]);
        reg_write(`OFS_ADDR_LO, a[7:0]);
        reg_write(`OFS_DATA_HI, d[15:8]);
        reg_write(`OFS_DATA_LO, d[7:0]);
        reg_write(`OFS_STATUS, 8'h80);
    endtask

    // ====
    // scenarios
    task automatic t_reset_regs();
        reg_read(`OFS_PROT, rd8);
        check_val(16'(rd8), 16'h00FF);
        reg_write(`OFS_RSVD, 8'hFF);
        reg_read(`OFS_RSVD, rd8);
        check_val(16'(rd8), 16'h0000);
        reg_read(4'hF, rd8);
        check_val(16'(rd8), 16'h0000);
        arr_read(16'h0020, 1'h0, rd16, res);
        check_val(rd16, `ERASED_WORD);
        $display("test reset_regs done");
    endtask

    task automatic t_codes();
        logic [7:0] codes [6] = '{8'h05, 8'h20, 8'h40, 8'h41, 8'h21, 8'hFF};
        foreach (codes[i]) begin
            reg_write(`OFS_CMD, codes[i]);
            reg_read(`OFS_CMD, rd8);
            check_val(16'(rd8), 16'(codes[i] & `CMD_IMPL_MASK));
        end
        reg_write(`OFS_IRQ_EN, 8'h04);
        launch(8'h21, 16'h0010, 16'h0000);
        reg_read(`OFS_STATUS, rd8);
        check_val(16'(rd8[4]), 16'h0001);
        check_val(16'(busy), 16'h0000);
        check_val(16'(irq), 16'h0001);
        reg_write(`OFS_IRQ_EN, 8'h00);
        settle(3);
        check_val(16'(irq), 16'h0000);
        reg_write(`OFS_IRQ_EN, 8'h04);
        settle(3);
        check_val(16'(irq), 16'h0001);
        reg_write(`OFS_IRQ_CLR, 8'h04);
        settle(3);
        check_val(16'(irq), 16'h0000);
        reg_write(`OFS_STATUS, 8'h30);
        reg_read(`OFS_STATUS, rd8);
        check_val(16'(rd8[4]), 16'h0000);
        $display("test codes done");
    endtask

    // entry: setting, command, address; viol bit i marks refusal
    task automatic t_protect();
        logic [31:0] tab [16] = '{32'hFF20FFFE, 32'h8420F800, 32'h8420F7FE, 32'h9C20C000,
            32'h9C20BFFE, 32'hA02041FE, 32'hA0204200, 32'hA3204FFE, 32'hA3205000, 32'hA3203FFE,
            32'h24201000, 32'h20204000, 32'h20204200, 32'h0420F800, 32'h0420F7FE, 32'hA0410000};
        logic [15:0] viol = 16'hD4AA;
        foreach (tab[i]) begin
            reg_write(`OFS_PROT, tab[i][31:24]);
            reg_read(`OFS_PROT, rd8);
            check_val(16'(rd8), 16'(tab[i][31:24]));
            launch(tab[i][23:16], tab[i][15:0], 16'hFFFF);
            settle(3);
            check_val(16'(busy), 16'(!viol[i]));
            wait_idle();
            reg_read(`OFS_STATUS, rd8);
            check_val(16'(rd8[5:4]), {14'h0, viol[i], 1'h0});
            reg_write(`OFS_STATUS, 8'h30);
        end
        reg_write(`OFS_PROT, 8'hFF);
        $display("test protect done");
    endtask

    task automatic t_array();
        launch(`CMD_PROG, 16'h0010, 16'h1234);
        arr_read(16'h0010, 1'h0, rd16, res);
        check_val(16'(res), 16'h0002);
        wait_idle();
        arr_read(16'h0010, 1'h0, rd16, res);
        check_val(rd16, 16'h1234);
        arr_read(16'h0011, 1'h1, rd16, res);
        check_val(rd16, 16'h0034);
        arr_read(16'h0011, 1'h0, rd16, res);
        check_val(rd16, 16'h34FF);
        launch(`CMD_SECT_ERASE, 16'h0010, 16'h0000);
        wait_idle();
        arr_read(16'h0010, 1'h0, rd16, res);
        check_val(rd16, `ERASED_WORD);
        launch(`CMD_PROG, 16'h0010, 16'h5A5A);
        launch(`CMD_MASS_ERASE, 16'h0000, 16'h0000);
        reg_read(`OFS_STATUS, rd8);
        check_val(16'(rd8[4]), 16'h0000);
        wait_idle();
        arr_read(16'h0010, 1'h0, rd16, res);
        check_val(rd16, `ERASED_WORD);
        reg_write(`OFS_IRQ_CLR, 8'h0F);
        launch(`CMD_VERIFY, 16'h0000, 16'h0000);
        wait_idle();
        reg_read(`OFS_STATUS, rd8);
        check_val(16'({rd8[6], rd8[2]}), 16'h0003);
        reg_read(`OFS_IRQ_STAT, rd8);
        check_val(16'(rd8[1:0]), 16'h0003);
        $display("test array done");
    endtask

    // ====
    // main sequence
    initial begin
        rst = 1'h1;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        arr_rd = 1'h0;
        arr_addr = 16'h0000;
        arr_byte = 1'h0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        t_reset_regs();
        t_codes();
        t_protect();
        t_array();
        finish_test();
    end

    // hang guard
    initial begin
        #900000;
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
